// file: bench/slcdr_lcd_board.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Display board: serial-in parallel-out chain with cascade output
// ----------------------------------------------------------------
module slcdr_lcd_board #(
   parameter logic [31:0] INIT = 32'hC3A5_5A3C
) (
   // Core clock used to watch the serial clock
   input wire logic sys_clk,
   // Serial pins and select
   input wire logic sclk,
   input wire logic sdat,
   input wire logic sel,
   // Edge choice of the board
   input wire logic clock_polarity_sel,
   input wire logic clock_phase_sel,
   // Cascade output and segment outputs
   output logic cascade_out,
   output logic [31:0] chain
);
   logic sclk_q;
   logic sel_q;
   logic lead;

   initial chain = INIT;

   // Shift on the chosen clock edge, one bit per edge
   always @(posedge sys_clk) begin
      sclk_q <= sclk;
      sel_q <= sel;
      lead = (sclk_q === clock_polarity_sel) && (sclk !== clock_polarity_sel);
      if ((sel || sel_q) && sclk !== sclk_q && lead == !clock_phase_sel) begin
         chain <= {chain[30:0], sdat};
      end
   end

   // Top of the chain feeds back as serial input
   assign cascade_out = chain[31];
endmodule // slcdr_lcd_board

`default_nettype wire

// file: bench/spi_static_lcd_refresher_bench.sv
`timescale 1ns/1ps
`default_nettype none

module spi_static_lcd_refresher_bench;
   // ----------------------------------------------------------------
   // Signals and tables
   // ----------------------------------------------------------------
   localparam int unsigned FRAME_N = 4000;
   localparam logic [7:0] PAT [16] = '{0: 8'h3F, 1: 8'h0C, 2: 8'h5B, 3: 8'h5E, 4: 8'h64,
      5: 8'h76, 6: 8'h77, 7: 8'h1C, 8: 8'h7F, 9: 8'h7E, default: 8'h00};
   localparam slcdr_pkg::slcdr_value_t VALS [5] = '{{8'h00, 4'h3, 4'h7, 4'h5, 3'h0},
      {8'hFF, 4'h0, 4'h1, 4'h2, 3'h5}, {8'h55, 4'h4, 4'h6, 4'h8, 3'h2},
      {8'h80, 4'h9, 4'hA, 4'hF, 3'h1}, {8'h00, 4'h3, 4'h7, 4'h5, 3'h0}};
   localparam logic [3:0][7:0] TX = {8'h7E, 8'h81, 8'h3C, 8'hA5};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   slcdr_pkg::slcdr_cfg_t cfg = '0;
   logic lcd_en = 1'b0;
   slcdr_pkg::slcdr_value_t lcd_value = '0;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic busy, irq_req, sin, sout, sclk, sclk_n, busy_n;
   logic [31:0] chain;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int tog = 0;
   int nb = 0;
   int fstart = 0;
   int fgap = 0;

   always #2 sys_clk = ~sys_clk;

   slcdr_top #(.FRAME_CYCLES(FRAME_N)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
      .lcd_en(lcd_en), .lcd_value(lcd_value), .serial_data_wr(wr),
      .serial_data_wdata(wdata), .serial_data_rdata(rdata), .busy(busy),
      .irq_req(irq_req), .serial_in_pin(sin), .serial_out_pin(sout), .serial_clk_pin(sclk));

   slcdr_lcd_board board (.sys_clk(sys_clk), .sclk(sclk), .sdat(sout), .sel(busy),
      .clock_polarity_sel(cfg.clock_polarity_sel), .clock_phase_sel(cfg.clock_phase_sel),
      .cascade_out(sin),
      .chain(chain));

   // ----------------------------------------------------------------
   // Monitors: cycles, clock toggles, byte ends, frame starts, timeout
   // ----------------------------------------------------------------
   always @(negedge sys_clk) begin
      cyc <= cyc + 1;
      sclk_n <= sclk;
      busy_n <= busy;
      if (sclk !== sclk_n) tog <= tog + 1;
      if (busy_n === 1'b1 && busy === 1'b0) nb <= nb + 1;
      if (busy_n === 1'b0 && busy === 1'b1 && nb % 4 == 0) begin
         fgap <= cyc - fstart;
         fstart <= cyc;
      end
      if (cyc == 60000) begin
         bad_count++;
         $display("BAD at %0t: run did not finish in time", $time);
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
      n_compared++;
      if (got !== want) begin
         bad_count++;
         $display("BAD at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask

   // Expected board image of one frame
   function automatic logic [31:0] frame(input slcdr_pkg::slcdr_value_t v, input logic inv);
      logic [31:0] img;
      img = {1'b0, v.symbols[6:0], v.decimal_point_segment[2], PAT[v.hundreds][6:0],
         v.decimal_point_segment[1], PAT[v.tens][6:0], v.decimal_point_segment[0],
         PAT[v.units][6:0]};
      return inv ? ~img : img;
   endfunction

   // One byte through the data register, with an optional refused write
   task automatic send(input slcdr_pkg::slcdr_cfg_t c, input logic [7:0] d, input bit spoil);
      int n;
      int h;
      logic [31:0] prev;
      n = 0;
      h = 8 << {c.speed_sel_hi, c.speed_sel_lo};
      @(posedge sys_clk) cfg <= c;
      repeat (4) @(posedge sys_clk);
      #1;
      check(sclk, c.clock_polarity_sel, "idle clock level");
      prev = chain;
      tog = 0;
      @(posedge sys_clk) begin
         wr <= 1'b1;
         wdata <= d;
      end
      @(posedge sys_clk) wr <= 1'b0;
      do begin
         @(posedge sys_clk);
         wr <= spoil && n == 3;
         wdata <= ~d;
         #1;
         n++;
      end while (busy === 1'b1 && n < 2000);
      check(n, 16 * h, "byte length");
      check(irq_req, c.irq_en, "end of byte request");
      check(rdata, prev[31:24], "received byte");
      @(posedge sys_clk);
      #1;
      check(irq_req, 1'b0, "request length");
      check(tog, 16, "clock toggles");
      check(chain, {prev[23:0], d}, "board contents");
   endtask

   // Wait until a byte count is reached with busy at a given level
   task automatic wait_nb(input int k, input logic b);
      int t;
      t = 0;
      while (!(nb >= k && busy === b) && t < 10000) begin
         @(negedge sys_clk);
         #1;
         t++;
      end
      if (t >= 10000) begin
         bad_count++;
         $display("BAD at %0t: no byte progress", $time);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      slcdr_pkg::slcdr_cfg_t c;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check({rdata, sout, busy, irq_req, sclk}, 12'h000, "reset state");
      tog = 0;
      repeat (50) @(posedge sys_clk);
      #1;
      check(tog, 0, "idle clock");
      check(busy, 1'b0, "idle busy");
      // Every clock mode and speed, one refused write among them
      for (int i = 0; i < 4; i++) begin
         c = slcdr_pkg::slcdr_cfg_t'({i[1], i[0], i[1], i[0], i != 2});
         send(c, TX[i], i == 1);
      end
      // Refresher frames, value changed while each frame is running
      @(posedge sys_clk) begin
         cfg <= '0;
         lcd_value <= VALS[0];
      end
      repeat (4) @(posedge sys_clk);
      nb = 0;
      @(posedge sys_clk) lcd_en <= 1'b1;
      for (int f = 0; f < 5; f++) begin
         wait_nb(4 * f, 1'b1);
         @(posedge sys_clk) lcd_value <= VALS[(f + 1) % 5];
         wait_nb(4 * f + 4, 1'b0);
         check(chain, frame(VALS[f], f[0]), "frame image");
         if (f > 0) check(fgap, FRAME_N, "frame spacing");
         @(posedge sys_clk) wr <= 1'b1;
         @(posedge sys_clk) wr <= 1'b0;
         repeat (3) @(posedge sys_clk);
         #1;
         check(busy, 1'b0, "write while refreshing");
      end
      wrap_up();
   end
endmodule // spi_static_lcd_refresher_bench

`default_nettype wire

// file: rtl/slcdr_pkg.sv
package slcdr_pkg;

   // ----------------------------------------------------------------
   // Serial engine timing
   // ----------------------------------------------------------------
   // Half period of the serial clock in core cycles, one per speed code
   localparam logic [7:0] SPD_HALF_0 = 8'h08;
   localparam logic [7:0] SPD_HALF_1 = 8'h10;
   localparam logic [7:0] SPD_HALF_2 = 8'h20;
   localparam logic [7:0] SPD_HALF_3 = 8'h40;
   // Clock edges per byte: two per bit
   localparam logic [3:0] LAST_EDGE = 4'hF;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // Refresh timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned FRAME_US = 16000;
   localparam int unsigned FRAME_CYC = FRAME_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // Display layout
   // ----------------------------------------------------------------
   localparam int unsigned BP_BIT = 7;
   localparam int unsigned POINT_BIT = 7;
   localparam logic [1:0] LAST_BYTE = 2'h3;
   localparam logic [3:0] MAX_DIGIT = 4'h9;
   localparam logic [7:0] SEG_BLANK = 8'h00;
   // Segment patterns for digits 0 to 9, entry n is digit n
   localparam logic [9:0][7:0] SEG_LUT = {
      8'h7E, 8'h7F, 8'h1C, 8'h77, 8'h76, 8'h64, 8'h5E, 8'h5B, 8'h0C, 8'h3F};

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic speed_sel_hi;
      logic speed_sel_lo;
      logic irq_en;
   } slcdr_cfg_t;

   typedef struct packed {
      logic [7:0] symbols;
      logic [3:0] hundreds;
      logic [3:0] tens;
      logic [3:0] units;
      logic [2:0] decimal_point_segment;
   } slcdr_value_t;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'h0,
      ENG_RUN = 2'h1
   } slcdr_eng_t;

   typedef enum logic [1:0] {
      REF_WAIT = 2'h0,
      REF_SEND = 2'h1,
      REF_BUSY = 2'h3
   } slcdr_ref_t;

endpackage

// file: rtl/slcdr_top.sv
// Notes on behaviour
// - Eight-bit shift register loaded and read in parallel, shifting through pins.
// - Only a write of a byte starts a transfer while lcd_en is low; while it is high the refresher starts them.
// - Each bit step drives the MSB out and captures input into the LSB.
// - One clock pulse per bit, stopping after eight pulses.
// - End of each byte raises an interrupt request when enabled.
// - Polarity chooses rising or falling transition as the active edge.
// - Phase chooses first or second edge of each pulse as active.
// - Two-bit speed field picks one of four serial clock rates.
// - Byte bits: 7 decimal point, then g, f, a, b, c, d, 0 e.
// - Digits 0..9 map through the fixed segment pattern table.
// - Segment lit when its level differs from the backplane level.
// - Four bytes hold all segments, backplane bit zero in the true frame.
// - Frames spaced about 16 ms apart.
// - Alternation gives drive frequency within 30 to 100 Hz.
`timescale 1ns/1ps
`default_nettype none

module slcdr_top #(
   parameter int unsigned FRAME_CYCLES = slcdr_pkg::FRAME_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Configuration
   input wire slcdr_pkg::slcdr_cfg_t cfg,
   input wire logic lcd_en,
   input wire slcdr_pkg::slcdr_value_t lcd_value,
   // Data register write and read
   input wire logic serial_data_wr,
   input wire logic [7:0] serial_data_wdata,
   output logic [7:0] serial_data_rdata,
   output logic busy,
   output logic irq_req,
   // Serial pins
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_clk_pin
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   slcdr_pkg::slcdr_eng_t eng_st_ff;
   slcdr_pkg::slcdr_ref_t ref_st_ff;
   logic [7:0] half_cnt_ff;
   logic [3:0] edge_ff;
   logic [7:0] shreg_ff;
   logic [7:0] rx_ff;
   logic samp_ff;
   logic sclk_ff;
   logic sout_ff;
   logic busy_ff;
   logic irq_ff;
   logic sin_s1_ff, sin_s2_ff, sin_s3_ff, sin_ff;
   logic [31:0] frame_cnt_ff;
   logic frame_tick;
   logic [1:0] idx_ff;
   logic inv_ff;
   logic [7:0] frame_ff [4];
   logic [7:0] half_len;
   logic half_tick;
   logic eng_done;
   logic start_req;
   logic [7:0] start_data;
   logic lcd_start;
   logic frame_last;

   // ----------------------------------------------------------------
   // Serial input synchroniser
   // ----------------------------------------------------------------
   // Three stages, value accepted once the last two agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sin_s1_ff <= 1'b0;
         sin_s2_ff <= 1'b0;
         sin_s3_ff <= 1'b0;
         sin_ff <= 1'b0;
      end else begin
         sin_s1_ff <= serial_in_pin;
         sin_s2_ff <= sin_s1_ff;
         sin_s3_ff <= sin_s2_ff;
         if (sin_s2_ff == sin_s3_ff) begin
            sin_ff <= sin_s3_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   // Speed code to half period
   always_comb begin
      case ({cfg.speed_sel_hi, cfg.speed_sel_lo})
         2'h0: half_len = slcdr_pkg::SPD_HALF_0;
         2'h1: half_len = slcdr_pkg::SPD_HALF_1;
         2'h2: half_len = slcdr_pkg::SPD_HALF_2;
         2'h3: half_len = slcdr_pkg::SPD_HALF_3;
         default: half_len = slcdr_pkg::SPD_HALF_0;
      endcase
   end

   // Requester select: the refresher owns the engine while enabled
   assign start_req = lcd_en ? lcd_start : serial_data_wr;
   assign start_data = lcd_en ? (frame_ff[idx_ff] ^ {8{inv_ff}}) : serial_data_wdata;
   assign half_tick = (eng_st_ff == slcdr_pkg::ENG_RUN) && (half_cnt_ff == half_len - 8'h01);
   assign eng_done = half_tick && (edge_ff == slcdr_pkg::LAST_EDGE);

   // Sequencer: sixteen clock edges per byte
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_st_ff <= slcdr_pkg::ENG_IDLE;
         half_cnt_ff <= 8'h00;
         edge_ff <= 4'h0;
         busy_ff <= 1'b0;
      end else begin
         case (eng_st_ff)
            slcdr_pkg::ENG_IDLE: begin
               if (start_req) begin
                  eng_st_ff <= slcdr_pkg::ENG_RUN;
                  busy_ff <= 1'b1;
                  half_cnt_ff <= 8'h00;
                  edge_ff <= 4'h0;
               end
            end
            slcdr_pkg::ENG_RUN: begin
               if (half_tick) begin
                  half_cnt_ff <= 8'h00;
                  edge_ff <= edge_ff + 4'h1;
                  if (eng_done) begin
                     eng_st_ff <= slcdr_pkg::ENG_IDLE;
                     busy_ff <= 1'b0;
                  end
               end else begin
                  half_cnt_ff <= half_cnt_ff + 8'h01;
               end
            end
            default: begin
               eng_st_ff <= slcdr_pkg::ENG_IDLE;
               busy_ff <= 1'b0;
            end
         endcase
      end
   end

   // Serial clock: rests at polarity level, toggles each half period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_ff <= 1'b0;
      end else if (eng_st_ff != slcdr_pkg::ENG_RUN) begin
         sclk_ff <= cfg.clock_polarity_sel;
      end else if (half_tick) begin
         sclk_ff <= ~sclk_ff;
      end
   end

   // Shift datapath; even edges lead each pulse, odd edges trail
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg_ff <= slcdr_pkg::BYTE_RST;
         samp_ff <= 1'b0;
         sout_ff <= 1'b0;
      end else if (eng_st_ff == slcdr_pkg::ENG_IDLE && start_req) begin
         shreg_ff <= start_data;
         if (!cfg.clock_phase_sel) begin
            sout_ff <= start_data[7];
         end
      end else if (half_tick) begin
         if (!edge_ff[0]) begin
            if (cfg.clock_phase_sel) begin
               sout_ff <= shreg_ff[7];
            end else begin
               samp_ff <= sin_ff;
            end
         end else begin
            shreg_ff <= {shreg_ff[6:0], cfg.clock_phase_sel ? sin_ff : samp_ff};
            if (!cfg.clock_phase_sel && !eng_done) begin
               sout_ff <= shreg_ff[6];
            end
         end
      end
   end

   // Received byte and end-of-byte request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_ff <= slcdr_pkg::BYTE_RST;
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= eng_done && cfg.irq_en;
         if (eng_done) begin
            rx_ff <= {shreg_ff[6:0], cfg.clock_phase_sel ? sin_ff : samp_ff};
         end
      end
   end

   // ----------------------------------------------------------------
   // Display refresher
   // ----------------------------------------------------------------
   // Frame period counter, 16 ms gives 31.25 Hz drive
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt_ff <= 32'h0000_0000;
      end else if (!lcd_en || frame_tick) begin
         frame_cnt_ff <= 32'h0000_0000;
      end else begin
         frame_cnt_ff <= frame_cnt_ff + 32'h0000_0001;
      end
   end
   assign frame_tick = lcd_en && (frame_cnt_ff == FRAME_CYCLES[31:0] - 32'h0000_0001);

   assign lcd_start = (ref_st_ff == slcdr_pkg::REF_SEND) && (eng_st_ff == slcdr_pkg::ENG_IDLE);
   assign frame_last = (ref_st_ff == slcdr_pkg::REF_BUSY) && eng_done
                       && (idx_ff == slcdr_pkg::LAST_BYTE);

   // Frame sequencer: four bytes, back to back
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_st_ff <= slcdr_pkg::REF_WAIT;
         idx_ff <= 2'h0;
         inv_ff <= 1'b0;
      end else begin
         case (ref_st_ff)
            slcdr_pkg::REF_WAIT: begin
               if (frame_tick) begin
                  ref_st_ff <= slcdr_pkg::REF_SEND;
                  idx_ff <= 2'h0;
               end
            end
            slcdr_pkg::REF_SEND: begin
               if (lcd_start) begin
                  ref_st_ff <= slcdr_pkg::REF_BUSY;
               end
            end
            slcdr_pkg::REF_BUSY: begin
               if (frame_last) begin
                  ref_st_ff <= slcdr_pkg::REF_WAIT;
                  inv_ff <= ~inv_ff;
               end else if (eng_done) begin
                  ref_st_ff <= slcdr_pkg::REF_SEND;
                  idx_ff <= idx_ff + 2'h1;
               end
            end
            default: ref_st_ff <= slcdr_pkg::REF_WAIT;
         endcase
         if (!lcd_en) begin
            ref_st_ff <= slcdr_pkg::REF_WAIT;
         end
      end
   end

   // Frame image captured only at frame start
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            frame_ff[i] <= slcdr_pkg::BYTE_RST;
         end
      end else if (ref_st_ff == slcdr_pkg::REF_WAIT && frame_tick) begin
         frame_ff[0] <= lcd_value.symbols & ~(8'h01 << slcdr_pkg::BP_BIT);
         frame_ff[1] <= seg_of(lcd_value.hundreds, lcd_value.decimal_point_segment[2]);
         frame_ff[2] <= seg_of(lcd_value.tens, lcd_value.decimal_point_segment[1]);
         frame_ff[3] <= seg_of(lcd_value.units, lcd_value.decimal_point_segment[0]);
      end
   end

   // Digit to segment byte, decimal point on the top bit
   function automatic logic [7:0] seg_of(input logic [3:0] dig, input logic point);
      logic [7:0] pat;
      pat = (dig <= slcdr_pkg::MAX_DIGIT) ? slcdr_pkg::SEG_LUT[dig] : slcdr_pkg::SEG_BLANK;
      pat[slcdr_pkg::POINT_BIT] = point;
      return pat;
   endfunction

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign serial_data_rdata = rx_ff;
   assign busy = busy_ff;
   assign irq_req = irq_ff;
   assign serial_out_pin = sout_ff;
   assign serial_clk_pin = sclk_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   logic [4:0] chk_edges_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_edges_ff <= 5'h00;
      end else if (eng_st_ff == slcdr_pkg::ENG_IDLE) begin
         chk_edges_ff <= 5'h00;
      end else if (half_tick) begin
         chk_edges_ff <= chk_edges_ff + 5'h01;
      end
   end

   a_start_cause: assert property ($rose(busy_ff) |-> $past(start_req))
      else $error("transfer began without a write");
   a_eight_pulses: assert property (eng_done |-> chk_edges_ff == 5'h0F ##1 !busy_ff)
      else $error("byte did not end after eight pulses");
   a_idle_level: assert property (!busy_ff |=> sclk_ff == $past(cfg.clock_polarity_sel))
      else $error("serial clock idle level wrong");
   a_irq_end: assert property (eng_done && cfg.irq_en |=> irq_ff ##1 !irq_ff)
      else $error("missing end of byte request");
   a_msb_first: assert property (eng_st_ff == slcdr_pkg::ENG_IDLE && start_req
      && !cfg.clock_phase_sel |=> sout_ff == $past(start_data[7]))
      else $error("first bit out is not the MSB");
   a_frame_alt: assert property (frame_last |=> inv_ff != $past(inv_ff))
      else $error("frame polarity did not alternate");
   // Backplane bit leaves at zero in a true frame and at one in a complemented frame
   a_bp_zero: assert property (lcd_start && idx_ff == 2'h0
      |-> start_data[slcdr_pkg::BP_BIT] == inv_ff)
      else $error("backplane bit does not follow frame polarity");
   a_value_hold: assert property (ref_st_ff != slcdr_pkg::REF_WAIT |=> $stable(frame_ff[3]))
      else $error("frame image changed mid frame");
   a_period_bound: assert property (frame_cnt_ff < FRAME_CYCLES)
      else $error("frame counter overran its period");

   c_mode3_byte: cover property (eng_done && cfg.clock_polarity_sel && cfg.clock_phase_sel);
   c_cpu_irq: cover property (!lcd_en && eng_done && cfg.irq_en);
   c_inv_frame: cover property (frame_last && inv_ff);

endmodule // slcdr_top

`default_nettype wire
